//--- src/sbsc_top.sv
// Cycle decoder, burst counter, write buffer and data pipeline of a synchronous burst SRAM.
`timescale 1ns/1ps
`include "sbsc_map.svh"

// Write buffer: a plain FIFO with valid and ready on both sides.
module sbsc_fifo
#(
  parameter int W = 8,
  parameter int DEPTH = `SBSC_WBUF_DEPTH
)
(
  // Clock and synchronous reset.
  input wire logic clk,
  input wire logic resetn,
  // Filling side.
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  // Draining side.
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);
  logic [W-1:0] mem [DEPTH]; // Storage, not reset since valid words are tracked by count.
  logic [PW-1:0] wr_ptr_ff, nxt_wr_ptr; // Next slot to fill.
  logic [PW-1:0] rd_ptr_ff, nxt_rd_ptr; // Oldest word.
  logic [CW-1:0] count_ff, nxt_count; // Words held.
  logic ready_ff, nxt_ready; // Registered room flag so the pin comes from a flop.
  logic push;
  logic pop;

  assign push = in_valid && ready_ff;
  assign pop = out_ready && (count_ff != '0);
  assign in_ready = ready_ff;
  assign out_valid = (count_ff != '0);
  assign out_data = mem[rd_ptr_ff];

  // Pointer and count arithmetic; pointers wrap at the depth, not at a power of two.
  always_comb
  begin
    nxt_wr_ptr = wr_ptr_ff;
    nxt_rd_ptr = rd_ptr_ff;
    nxt_count = count_ff;
    if (push)
    begin
      nxt_wr_ptr = (wr_ptr_ff == PW'(DEPTH - 1)) ? '0 : wr_ptr_ff + 1'b1;
    end
    if (pop)
    begin
      nxt_rd_ptr = (rd_ptr_ff == PW'(DEPTH - 1)) ? '0 : rd_ptr_ff + 1'b1;
    end
    if (push && !pop)
    begin
      nxt_count = count_ff + 1'b1;
    end
    else if (pop && !push)
    begin
      nxt_count = count_ff - 1'b1;
    end
    nxt_ready = (nxt_count != CW'(DEPTH));
  end

  // Registers of the buffer.
  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
      count_ff <= '0;
      ready_ff <= 1'b1;
    end
    else
    begin
      wr_ptr_ff <= nxt_wr_ptr;
      rd_ptr_ff <= nxt_rd_ptr;
      count_ff <= nxt_count;
      ready_ff <= nxt_ready;
    end
  end

  // Storage write, kept apart since the array has no reset.
  always_ff @(posedge clk)
  begin
    if (push)
    begin
      mem[wr_ptr_ff] <= in_data;
    end
  end
endmodule

// Top of the synchronous burst SRAM core.
module sbsc_top
  import sbsc_pkg::*;
#(
  parameter int ADDR_W = `SBSC_ADDR_W,
  parameter int LANES = `SBSC_LANES,
  parameter int LANE_W = `SBSC_LANE_W,
  parameter int WBUF_DEPTH = `SBSC_WBUF_DEPTH
)
(
  // Clock and synchronous active-low reset.
  input wire logic CLK_SYS,
  input wire logic RESETN,
  // Address and cycle controls, sampled on the rising edge.
  input wire logic [ADDR_W-1:0] ADDR,
  input wire logic CHIP_SELECT_PRIMARY_N,
  input wire logic PROCESSOR_ADDRESS_STROBE_N,
  input wire logic CONTROLLER_ADDRESS_STROBE_N,
  input wire logic BURST_ADVANCE_N,
  // Write controls.
  input wire logic ALL_BYTE_WRITE_N,
  input wire logic BYTE_WRITE_GATE_N,
  input wire logic [LANES-1:0] LANE_WRITE_N,
  // Mode and asynchronous output enable.
  input wire logic LINEAR_ORDER_SEL_N,
  input wire logic OUTPUT_ENABLE_N,
  // Data pins split into input, output and enable.
  input wire logic [LANES*LANE_W-1:0] DQ_IN,
  output logic [LANES*LANE_W-1:0] DQ_OUT,
  output logic DQ_OE,
  // Room left in the write buffer.
  output logic WBUF_READY
);
  localparam int DW = LANES * LANE_W;
  localparam int LW = `SBSC_LOW_W;
  localparam int WB_W = ADDR_W + LANES + DW;

  // Low address bits of the burst: linear adds, interleaved exclusive-ors.
  function automatic logic [LW-1:0] burst_low(input logic [LW-1:0] start,
                                              input logic [LW-1:0] step,
                                              input logic interleave);
    burst_low = interleave ? (start ^ step) : LW'(start + step);
  endfunction

  logic [DW-1:0] mem [2**ADDR_W]; // The memory array.
  sbsc_cyc_t cyc; // Decoded kind of this cycle.
  logic wq; // Write qualifier.
  logic [LANES-1:0] lane_en; // Lanes written by this cycle.
  logic [ADDR_W-1:0] cyc_addr; // Address that this cycle uses.
  logic [ADDR_W-LW-1:0] upper_ff, nxt_upper; // Upper address held for the burst.
  logic [LW-1:0] start_ff, nxt_start; // Loaded low bits.
  logic [LW-1:0] cnt_ff, nxt_cnt; // Burst step count.
  logic inter_ff, nxt_inter; // Order captured at the burst start.
  logic rd_v_ff, nxt_rd_v; // Read sampled last edge.
  logic [ADDR_W-1:0] rd_addr_ff, nxt_rd_addr; // Its address.
  logic drv_ff, nxt_drv; // Output stage holds read data.
  logic [DW-1:0] q_ff, nxt_q; // Output stage data.
  logic is_rd, is_wr;
  logic wb_valid, wb_ready;
  logic [WB_W-1:0] wb_data;

  // Write qualifier and lane selection.
  always_comb
  begin
    wq = !ALL_BYTE_WRITE_N || (!BYTE_WRITE_GATE_N && (LANE_WRITE_N != '1));
    lane_en = !ALL_BYTE_WRITE_N ? '1 : ~LANE_WRITE_N;
  end

  // Cycle decode; a deselect ignores the processor strobe.
  always_comb
  begin
    if (CHIP_SELECT_PRIMARY_N && !CONTROLLER_ADDRESS_STROBE_N)
    begin
      cyc = SBSC_DESEL;
    end
    else if (!CHIP_SELECT_PRIMARY_N && !PROCESSOR_ADDRESS_STROBE_N)
    begin
      cyc = SBSC_RD_BEGIN;
    end
    else if (!CHIP_SELECT_PRIMARY_N && !CONTROLLER_ADDRESS_STROBE_N)
    begin
      cyc = wq ? SBSC_WR_BEGIN : SBSC_RD_BEGIN;
    end
    else if (!BURST_ADVANCE_N)
    begin
      cyc = wq ? SBSC_WR_NEXT : SBSC_RD_NEXT;
    end
    else
    begin
      cyc = wq ? SBSC_WR_HOLD : SBSC_RD_HOLD;
    end
  end

  // Burst state and address of this cycle.
  always_comb
  begin
    nxt_upper = upper_ff;
    nxt_start = start_ff;
    nxt_cnt = cnt_ff;
    nxt_inter = inter_ff;
    is_rd = (cyc == SBSC_RD_BEGIN) || (cyc == SBSC_RD_NEXT) || (cyc == SBSC_RD_HOLD);
    is_wr = (cyc == SBSC_WR_BEGIN) || (cyc == SBSC_WR_NEXT) || (cyc == SBSC_WR_HOLD);
    cyc_addr = {upper_ff, burst_low(start_ff, cnt_ff, inter_ff)};
    case (cyc)
      SBSC_RD_BEGIN, SBSC_WR_BEGIN:
      begin
        // External address used now; counter cleared and start taken from its low bits.
        cyc_addr = ADDR;
        nxt_upper = ADDR[ADDR_W-1:LW];
        nxt_start = ADDR[LW-1:0];
        nxt_cnt = `SBSC_CNT_RST;
        nxt_inter = LINEAR_ORDER_SEL_N;
      end
      SBSC_RD_NEXT, SBSC_WR_NEXT:
      begin
        // Step then use; wraps to the start after the fourth address.
        nxt_cnt = LW'(cnt_ff + 1'b1);
        cyc_addr = {upper_ff, burst_low(start_ff, nxt_cnt, inter_ff)};
      end
      default:
      begin
        // Hold and deselect keep the counter where it is.
        nxt_cnt = cnt_ff;
      end
    endcase
  end

  // Read pipeline: address stage, then array read into the output stage.
  always_comb
  begin
    nxt_rd_v = is_rd;
    nxt_rd_addr = is_rd ? cyc_addr : rd_addr_ff;
    nxt_drv = rd_v_ff;
    nxt_q = rd_v_ff ? mem[rd_addr_ff] : q_ff;
  end

  // Control registers.
  always_ff @(posedge CLK_SYS)
  begin
    if (!RESETN)
    begin
      upper_ff <= '0;
      start_ff <= '0;
      cnt_ff <= `SBSC_CNT_RST;
      inter_ff <= 1'b0;
      rd_v_ff <= 1'b0;
      rd_addr_ff <= '0;
      drv_ff <= 1'b0;
      q_ff <= '0;
    end
    else
    begin
      upper_ff <= nxt_upper;
      start_ff <= nxt_start;
      cnt_ff <= nxt_cnt;
      inter_ff <= nxt_inter;
      rd_v_ff <= nxt_rd_v;
      rd_addr_ff <= nxt_rd_addr;
      drv_ff <= nxt_drv;
      q_ff <= nxt_q;
    end
  end

  // Write data is captured with the address; lost if the buffer is full.
  assign wb_valid = is_wr;
  assign wb_data = {cyc_addr, lane_en, DQ_IN};

  logic wr_v; // Buffer head is present.
  logic [WB_W-1:0] wr_word; // Buffer head.
  logic wr_take; // Head goes to the array this cycle.

  // The array has one port; reads win it, so writes wait and the buffer can fill.
  assign wr_take = wr_v && !rd_v_ff;

  sbsc_fifo #(.W(WB_W), .DEPTH(WBUF_DEPTH)) u_wbuf (
    .clk(CLK_SYS),
    .resetn(RESETN),
    .in_valid(wb_valid),
    .in_ready(wb_ready),
    .in_data(wb_data),
    .out_valid(wr_v),
    .out_ready(!rd_v_ff),
    .out_data(wr_word)
  );

  // Lane-masked array write from the buffer head.
  always_ff @(posedge CLK_SYS)
  begin
    for (int i = 0; i < LANES; i++)
    begin
      if (wr_take && wr_word[DW+i])
      begin
        mem[wr_word[WB_W-1 -: ADDR_W]][i*LANE_W +: LANE_W] <= wr_word[i*LANE_W +: LANE_W];
      end
    end
  end

  // Pins: the output enable gates the driver without waiting for a clock.
  assign DQ_OUT = q_ff;
  assign DQ_OE = drv_ff && !OUTPUT_ENABLE_N;
  assign WBUF_READY = wb_ready;

  property p_desel_release;
    @(posedge CLK_SYS) disable iff (!RESETN)
    (CHIP_SELECT_PRIMARY_N && !CONTROLLER_ADDRESS_STROBE_N) |=> ##1 !DQ_OE;
  endproperty
  a_desel_release: assert property (p_desel_release) else $error("Pins driven after deselect.");

  property p_rd_begin;
    @(posedge CLK_SYS) disable iff (!RESETN)
    (!CHIP_SELECT_PRIMARY_N && !PROCESSOR_ADDRESS_STROBE_N)
      |=> rd_v_ff && rd_addr_ff == $past(ADDR) && cnt_ff == 2'h0;
  endproperty
  a_rd_begin: assert property (p_rd_begin) else $error("Read begin not at external address.");

  property p_wr_begin;
    @(posedge CLK_SYS) disable iff (!RESETN)
    (cyc == SBSC_WR_BEGIN) |-> wb_valid && wb_data[WB_W-1 -: ADDR_W] == ADDR && !nxt_rd_v;
  endproperty
  a_wr_begin: assert property (p_wr_begin) else $error("Write begin not queued.");

  property p_next_step;
    @(posedge CLK_SYS) disable iff (!RESETN)
    (cyc == SBSC_RD_NEXT || cyc == SBSC_WR_NEXT) |=> cnt_ff == 2'($past(cnt_ff) + 1'b1);
  endproperty
  a_next_step: assert property (p_next_step) else $error("Burst counter did not step.");

  property p_hold;
    @(posedge CLK_SYS) disable iff (!RESETN)
    (cyc == SBSC_RD_HOLD || cyc == SBSC_WR_HOLD) |=> $stable(cnt_ff) && $stable(upper_ff);
  endproperty
  a_hold: assert property (p_hold) else $error("Suspended burst moved.");

  property p_oe_async;
    @(posedge CLK_SYS) disable iff (!RESETN)
    OUTPUT_ENABLE_N |-> !DQ_OE;
  endproperty
  a_oe_async: assert property (p_oe_async) else $error("Driving with output enable high.");

  property p_drive_only_read;
    @(posedge CLK_SYS) disable iff (!RESETN)
    DQ_OE |-> $past(is_rd, 2);
  endproperty
  a_drive_only_read: assert property (p_drive_only_read) else $error("Drove without a read.");

  property p_dummy_read;
    @(posedge CLK_SYS) disable iff (!RESETN)
    (OUTPUT_ENABLE_N && cyc == SBSC_RD_NEXT) |=> cnt_ff != $past(cnt_ff);
  endproperty
  a_dummy_read: assert property (p_dummy_read) else $error("Dummy read did not advance.");

  property p_wrap;
    @(posedge CLK_SYS) disable iff (!RESETN)
    (cyc == SBSC_RD_BEGIN) ##1 (cyc == SBSC_RD_NEXT) [*4] |=> rd_addr_ff == $past(rd_addr_ff, 4);
  endproperty
  a_wrap: assert property (p_wrap) else $error("Burst did not wrap after four.");

  property p_upper_kept;
    @(posedge CLK_SYS) disable iff (!RESETN)
    (cyc == SBSC_RD_NEXT) |=> rd_addr_ff[ADDR_W-1:LW] == $past(upper_ff);
  endproperty
  a_upper_kept: assert property (p_upper_kept) else $error("Upper address lost in burst.");

  property p_read_latency;
    @(posedge CLK_SYS) disable iff (!RESETN)
    is_rd |=> ##1 drv_ff;
  endproperty
  a_read_latency: assert property (p_read_latency) else $error("Read data stage missing.");
endmodule

//--- shared/sbsc_map.svh
// Sizes, reset values and buffer depth of the burst SRAM cycle control.
`ifndef SBSC_MAP_SVH
`define SBSC_MAP_SVH
`define SBSC_ADDR_W 18
`define SBSC_LANES 8
`define SBSC_LANE_W 9
`define SBSC_WBUF_DEPTH 16
`define SBSC_CNT_RST 2'h0
`define SBSC_LOW_W 2
`endif

//--- shared/sbsc_pkg.sv
// Types shared by the burst SRAM cycle control.
package sbsc_pkg;
  // Kind of cycle decoded from the sampled control pins.
  typedef enum logic [2:0] {
    SBSC_DESEL = 3'b000,
    SBSC_RD_BEGIN = 3'b001,
    SBSC_WR_BEGIN = 3'b010,
    SBSC_RD_NEXT = 3'b011,
    SBSC_WR_NEXT = 3'b100,
    SBSC_RD_HOLD = 3'b101,
    SBSC_WR_HOLD = 3'b110
  } sbsc_cyc_t;
endpackage

//--- tb/sbsc_ctl_model.sv
// Behavioural memory controller that drives the pin bus of the burst SRAM core.
`timescale 1ns/1ps
module sbsc_ctl_model
(
  // Clock of the pin bus.
  input wire logic clk,
  // Address and cycle controls toward the core.
  output logic [17:0] addr,
  output logic cs_n,
  output logic ps_n,
  output logic cc_n,
  output logic burst_advance_n,
  // Write controls, mode and output enable.
  output logic all_byte_write_n,
  output logic byte_write_gate_n,
  output logic [7:0] lane_n,
  output logic linear_order_sel_n,
  output logic oe_n,
  // Data that the controller puts on the shared pins.
  output logic [71:0] dq
);
  // Start deselected with outputs disabled, so reset sees a quiet bus.
  initial
  begin
    {addr, lane_n, dq} = {18'h0, 8'hff, 72'h0};
    {cs_n, ps_n, cc_n, burst_advance_n, all_byte_write_n, byte_write_gate_n, linear_order_sel_n,
      oe_n} = 8'hdd;
  end

  // One bus cycle: change just after the edge, hold until the next edge samples it.
  // Any pin pattern may be sent, so tied-strobe styles are just values of c.
  task automatic put(input logic [17:0] a, input logic [7:0] c, input logic [7:0] ln,
                     input logic [71:0] d);
    @(posedge clk);
    #1;
    addr = a;
    {cs_n, ps_n, cc_n, burst_advance_n, all_byte_write_n, byte_write_gate_n, linear_order_sel_n,
      oe_n} = c;
    lane_n = ln;
    // Data is driven whenever the write controls qualify, even on a processor-strobe read begin.
    if (!c[3] || (!c[2] && !(&ln)))
      dq = d;
    else
      dq = ~dq;  // Released bus: a changing pattern, never a stale value.
  endtask

  // Drive the output enable at once, off the clock.
  task automatic set_oe(input logic v);
    oe_n = v;
  endtask
endmodule

//--- tb/tb_top.sv
// Self-checking testbench of the burst SRAM core driven by the controller model.
`timescale 1ns/1ps
module tb_top;
  logic CLK_SYS = 1'b0;  // System clock, 50 MHz.
  logic RESETN = 1'b0;  // Synchronous reset, active low.
  logic [17:0] addr;
  logic cs_n, ps_n, cc_n, burst_advance_n, oe_n;
  logic all_byte_write_n, byte_write_gate_n, linear_order_sel_n;
  logic [7:0] lane_n;
  logic [71:0] dq_m, dq_out, dq_in;
  logic dq_oe, wbuf_ready;
  int n_mismatch = 0;
  int n_checks = 0;
  integer seed = 32'hbbd72db1;
  logic [71:0] mem [int];  // Reference contents of the array.
  logic [17:0] base;  // Address loaded at burst start.
  logic [17:0] blk [2];
  logic [1:0] cnt;
  logic ord;
  logic [73:0] cur = '0;  // Expectation {read, known, data} of the cycle on the pins.
  logic [73:0] p0 = '0;
  logic [73:0] chk_e;

  // Clock generator.
  always #10 CLK_SYS = ~CLK_SYS;

  // The shared data wire: the core wins while it drives.
  assign dq_in = dq_oe ? dq_out : dq_m;

  sbsc_ctl_model i_ctl (.clk(CLK_SYS), .addr(addr), .cs_n(cs_n), .ps_n(ps_n), .cc_n(cc_n),
    .burst_advance_n(burst_advance_n), .all_byte_write_n(all_byte_write_n),
    .byte_write_gate_n(byte_write_gate_n), .lane_n(lane_n),
    .linear_order_sel_n(linear_order_sel_n), .oe_n(oe_n), .dq(dq_m));

  sbsc_top i_dut (.CLK_SYS(CLK_SYS), .RESETN(RESETN), .ADDR(addr),
    .CHIP_SELECT_PRIMARY_N(cs_n), .PROCESSOR_ADDRESS_STROBE_N(ps_n),
    .CONTROLLER_ADDRESS_STROBE_N(cc_n), .BURST_ADVANCE_N(burst_advance_n),
    .ALL_BYTE_WRITE_N(all_byte_write_n), .BYTE_WRITE_GATE_N(byte_write_gate_n),
    .LANE_WRITE_N(lane_n), .LINEAR_ORDER_SEL_N(linear_order_sel_n),
    .OUTPUT_ENABLE_N(oe_n), .DQ_IN(dq_in), .DQ_OUT(dq_out), .DQ_OE(dq_oe),
    .WBUF_READY(wbuf_ready));

  // Compare one value and count it.
  task automatic chk(input logic [71:0] seen, input logic [71:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  // Print the counts and the verdict, then stop.
  task automatic close_out();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // Random wide data word.
  function automatic logic [71:0] rnd72();
    return 72'({$random(seed), $random(seed), $random(seed)});
  endfunction

  // Issue one cycle and predict what the core must do with it.
  // c holds {chip select, proc strobe, ctrl strobe, advance, all write, gate, order, oe}.
  task automatic cyc(input logic [17:0] a, input logic [7:0] c, input logic [7:0] ln,
                     input logic [71:0] d);
    logic q;
    logic [17:0] u;
    logic [71:0] m;
    int k;
    q = !c[3] || (!c[2] && !(&ln));
    i_ctl.put(a, c, ln, d);
    cur = '0;
    if (c[7] && !c[5])
      return;  // Deselect addresses nothing.
    if ((!c[7] && !c[6]) || !c[5])
    begin
      base = a;  // A begin loads the external address.
      cnt = 2'h0;
      ord = c[1];
      if (!c[6])
        q = 1'b0;  // Processor strobe always reads.
    end
    else if (!c[4])
      cnt = cnt + 2'h1;  // Continue steps before use; suspend keeps it.
    u = {base[17:2], ord ? base[1:0] ^ cnt : base[1:0] + cnt};
    k = mem.exists(int'(u));
    if (q)
    begin
      m = (k != 0) ? mem[int'(u)] : 72'h0;
      for (int i = 0; i < 8; i++)
        if (!c[3] || !ln[i])
          m[i*9 +: 9] = d[i*9 +: 9];  // Only enabled lanes change.
      mem[int'(u)] = m;
    end
    else
      cur = {1'b1, k[0], (k != 0) ? mem[int'(u)] : 72'h0};
  endtask

  // Pin monitor: a cycle sampled at the last edge shows its outcome one edge later.
  always @(posedge CLK_SYS)
  begin
    chk_e = p0;
    p0 = cur;
    #2;
    chk(72'(dq_oe), 72'(chk_e[73] && !oe_n));
    if (chk_e[73] && chk_e[72] && !oe_n)
      chk(dq_out, chk_e[71:0]);
  end

  // Cut a hang short.
  initial
  begin
    #100000;
    n_mismatch++;
    close_out();
  end

  // Main sequence.
  initial
  begin
    repeat (4) @(posedge CLK_SYS);
    #1;
    RESETN = 1'b1;
    chk(72'(dq_oe), 72'h0);
    chk(72'(wbuf_ready), 72'h1);
    // Fill one block per order from a random start; the four writes cover the whole block.
    for (int b = 0; b < 2; b++)
    begin
      blk[b] = 18'($random(seed));
      cyc(blk[b], (b != 0) ? 8'h57 : 8'h55, 8'hff, rnd72());
      cyc(18'($random(seed)), 8'h65, 8'hff, rnd72());
      repeat (2) cyc(18'($random(seed)), 8'he5, 8'hff, rnd72());
    end
    cyc(18'h0, 8'h79, 8'($random(seed)) & 8'hfe, rnd72());
    // Idle long enough for the write buffer to drain.
    repeat (20) cyc(18'($random(seed)), ($random(seed) & 1) ? 8'hdd : 8'h9d, 8'h00, 72'h0);
    for (int b = 0; b < 2; b++)
    begin
      cyc(blk[b] ^ 18'($random(seed) & 3), (b != 0) ? 8'h36 : 8'h34, 8'h00, rnd72());
      repeat (5) cyc(18'($random(seed)), (b != 0) ? 8'hec : 8'h6c, 8'hff, 72'h0);
      cyc(18'h0, 8'h7c, 8'hff, 72'h0);
      cyc(18'h0, 8'hbc, 8'hff, 72'h0);
      #9;
      i_ctl.set_oe(1'b1);
      #1;
      chk(72'(dq_oe), 72'h0);
    end
    // Controller-strobe read with the lane gate on but no lane chosen, then dummy reads.
    cyc(blk[0], 8'h58, 8'hff, rnd72());
    repeat (2) cyc(18'h0, 8'h6d, 8'hff, 72'h0);
    // A second enabled read keeps the output enable low while the first one is compared.
    repeat (2) cyc(18'h0, 8'h6c, 8'hff, 72'h0);
    // Random read-side traffic over the written blocks.
    repeat (300)
      cyc(blk[$random(seed) & 1] ^ 18'($random(seed) & 3), 8'($random(seed)) | 8'h08, 8'hff,
          rnd72());
    repeat (3) cyc(18'h0, 8'hdd, 8'hff, 72'h0);
    close_out();
  end
endmodule
